/* hw/sweep_handler_defines.svh */
// Contract
// - One fail output per sweep point, ten points.
// - Any-point-fail set when any point fails.
// - Fail outputs update only at sweep completion.
// - Whole-list: analog-done after final point's analog.
// - Whole-list: end strobe after all results valid.
// - Step: analog-done after each point's analog.
// - Step: end strobe after each step's compare.
// - External trigger rising edge starts a measurement.
`ifndef SWEEP_HANDLER_DEFINES_SVH
`define SWEEP_HANDLER_DEFINES_SVH
`define NUM_POINTS 10
`define ADDR_CTRL 32'h0000_0000
`define ADDR_STATUS 32'h0000_0004
`define ADDR_RESULT 32'h0000_0008
`define ADDR_IRQ_STAT 32'h0000_000C
`define ADDR_IRQ_EN 32'h0000_0010
`define ADDR_IRQ_CLR 32'h0000_0014
`define ADDR_NPOINTS 32'h0000_0018
`define CTRL_WHOLE_LIST 0
`define CTRL_EXTERNAL_TRIGGER_EDGE 1
`define CTRL_SW_START 2
`define CTRL_RESET 32'h0000_0001
`define NPOINTS_RESET 4'ha
`define IRQ_ANALOG 0
`define IRQ_END 1
`define IRQ_TRIG 2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* hw/sweep_handler_pkg.sv */
package sweep_handler_pkg;
   typedef enum logic [2:0] {
      S_IDLE,
      S_ANALOG,
      S_COMPARE,
      S_DONE
   } sweep_state_t;
endpackage

/* hw/edge_detect.sv */
`timescale 1ns/1ps
`default_nettype none
// Rising edge detector on an input already synchronous to aclk.
module edge_detect (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Level in, pulse out.
   input wire logic level_in,
   output logic rise_pulse
);
   logic prev_ff;

   // Remember the last level; reset high so a high level at release
   // does not count as an edge until it has been seen low first.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_ff <= 1'b1;
      end else begin
         prev_ff <= level_in;
      end
   end

   // Edge is a fresh high after a low.
   assign rise_pulse = level_in & ~prev_ff;
endmodule
`default_nettype wire

/* hw/list_sweep_handler_outputs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sweep_handler_defines.svh"
// Handler-port result and strobe logic for a list sweep.
module list_sweep_handler_outputs (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Handler trigger input.
   input wire logic external_trigger_edge,
   // Measurement engine side.
   output logic point_start,
   output logic [3:0] point_index,
   input wire logic analog_done_in,
   input wire logic compare_done_in,
   input wire logic compare_fail_in,
   // Handler outputs.
   output logic [9:0] point_fail,
   output logic any_point_fail,
   output logic analog_done_strobe,
   output logic measure_complete_strobe,
   output logic irq,
   // AXI4-Lite write address.
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data.
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address.
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data.
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   sweep_handler_pkg::sweep_state_t state_ff;
   logic [31:0] ctrl_ff;
   logic [3:0] npoints_ff;
   logic [3:0] idx_ff;
   logic [9:0] work_fail_ff;
   logic [9:0] point_fail_ff;
   logic any_fail_ff;
   logic analog_ff;
   logic end_ff;
   logic [2:0] irq_stat_ff;
   logic [2:0] irq_en_ff;
   logic aw_hold_ff;
   logic w_hold_ff;
   logic [31:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic bvalid_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic [1:0] bresp_ff;
   logic trig_rise;
   logic start_req;
   logic wr_fire;
   logic wr_ctrl;
   logic last_point;
   logic [2:0] irq_set;
   logic [2:0] irq_clr;
   logic sw_start;
   logic [9:0] nxt_work;

   // Byte-lane merge for a register write.
   function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   edge_detect trig_edge_u (
      .aclk(aclk),
      .aresetn(aresetn),
      .level_in(external_trigger_edge),
      .rise_pulse(trig_rise)
   );

   // Write fires once both address and data are held.
   assign wr_fire = aw_hold_ff & w_hold_ff & ~bvalid_ff;
   assign wr_ctrl = wr_fire && (awaddr_ff == `ADDR_CTRL);
   assign sw_start = wr_ctrl & wstrb_ff[0] & wdata_ff[`CTRL_SW_START];
   // Trigger only counts in external trigger mode.
   assign start_req = (state_ff == sweep_handler_pkg::S_IDLE) &
      ((trig_rise & ctrl_ff[`CTRL_EXTERNAL_TRIGGER_EDGE]) | sw_start);
   assign last_point = (idx_ff + 4'h1 >= npoints_ff);
   assign nxt_work = work_fail_ff | (10'(compare_fail_in) << idx_ff);

   // Measurement sequencer.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= sweep_handler_pkg::S_IDLE;
         idx_ff <= 4'h0;
         work_fail_ff <= 10'h000;
      end else begin
         case (state_ff)
            sweep_handler_pkg::S_IDLE: begin
               if (start_req) begin
                  state_ff <= sweep_handler_pkg::S_ANALOG;
                  idx_ff <= 4'h0;
                  work_fail_ff <= 10'h000;
               end
            end
            sweep_handler_pkg::S_ANALOG: begin
               if (analog_done_in) begin
                  state_ff <= sweep_handler_pkg::S_COMPARE;
               end
            end
            sweep_handler_pkg::S_COMPARE: begin
               if (compare_done_in) begin
                  work_fail_ff <= nxt_work;
                  if (last_point) begin
                     state_ff <= sweep_handler_pkg::S_DONE;
                  end else begin
                     idx_ff <= idx_ff + 4'h1;
                     state_ff <= sweep_handler_pkg::S_ANALOG;
                  end
               end
            end
            sweep_handler_pkg::S_DONE: begin
               state_ff <= sweep_handler_pkg::S_IDLE;
            end
            default: begin
               state_ff <= sweep_handler_pkg::S_IDLE;
            end
         endcase
      end
   end

   // Results move to the pins only at sweep end, so the handler never
   // sees a half-updated pattern.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         point_fail_ff <= 10'h000;
         any_fail_ff <= 1'b0;
      end else if (state_ff == sweep_handler_pkg::S_COMPARE &&
                   compare_done_in && last_point) begin
         point_fail_ff <= nxt_work;
         any_fail_ff <= |nxt_work;
      end
   end

   // Analog-done strobe: every point in step mode, last point in
   // whole-list mode. Cleared when a new sweep begins.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         analog_ff <= 1'b0;
      end else if (start_req) begin
         analog_ff <= 1'b0;
      end else if (state_ff == sweep_handler_pkg::S_ANALOG &&
                   analog_done_in) begin
         if (ctrl_ff[`CTRL_WHOLE_LIST]) begin
            analog_ff <= last_point ? 1'b1 : analog_ff;
         end else begin
            analog_ff <= 1'b1;
         end
      end else if (state_ff == sweep_handler_pkg::S_ANALOG &&
                   !ctrl_ff[`CTRL_WHOLE_LIST]) begin
         analog_ff <= 1'b0;
      end
   end

   // End strobe: per step in step mode, after the result latch in
   // whole-list mode, one cycle later so results are already stable.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         end_ff <= 1'b0;
      end else if (start_req) begin
         end_ff <= 1'b0;
      end else if (state_ff == sweep_handler_pkg::S_DONE) begin
         end_ff <= 1'b1;
      end else if (state_ff == sweep_handler_pkg::S_COMPARE &&
                   compare_done_in && !ctrl_ff[`CTRL_WHOLE_LIST] &&
                   !last_point) begin
         end_ff <= 1'b1;
      end else if (state_ff == sweep_handler_pkg::S_ANALOG &&
                   !ctrl_ff[`CTRL_WHOLE_LIST]) begin
         end_ff <= 1'b0;
      end
   end

   assign point_fail = point_fail_ff;
   assign any_point_fail = any_fail_ff;
   assign analog_done_strobe = analog_ff;
   assign measure_complete_strobe = end_ff;
   assign point_start = (state_ff == sweep_handler_pkg::S_ANALOG);
   assign point_index = idx_ff;

   // Sticky interrupt status; a set in the clear cycle wins.
   assign irq_set[`IRQ_ANALOG] = (state_ff == sweep_handler_pkg::S_ANALOG)
      & analog_done_in;
   assign irq_set[`IRQ_END] = (state_ff == sweep_handler_pkg::S_DONE);
   assign irq_set[`IRQ_TRIG] = trig_rise;
   assign irq_clr = (wr_fire && awaddr_ff == `ADDR_IRQ_CLR && wstrb_ff[0]) ?
      wdata_ff[2:0] : 3'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_ff <= 3'h0;
      end else begin
         irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
      end
   end

   assign irq = |(irq_stat_ff & irq_en_ff);

   // Control, enable and point-count registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff <= `CTRL_RESET;
         irq_en_ff <= 3'h0;
         npoints_ff <= `NPOINTS_RESET;
      end else if (wr_fire) begin
         if (awaddr_ff == `ADDR_CTRL) begin
            ctrl_ff <= merge_be(ctrl_ff, wdata_ff, wstrb_ff) &
               32'h0000_0003;
         end
         if (awaddr_ff == `ADDR_IRQ_EN && wstrb_ff[0]) begin
            irq_en_ff <= wdata_ff[2:0];
         end
         if (awaddr_ff == `ADDR_NPOINTS && wstrb_ff[0]) begin
            // A count of zero or above ten would be meaningless.
            if (wdata_ff[3:0] != 4'h0 && wdata_ff[3:0] <= 4'ha) begin
               npoints_ff <= wdata_ff[3:0];
            end
         end
      end
   end

   // Write channel capture: address and data taken in either order.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         awaddr_ff <= 32'h0000_0000;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= (awaddr_ff > `ADDR_NPOINTS ||
               awaddr_ff[1:0] != 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
   assign s_axi_wready = ~w_hold_ff & ~bvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;

   // Read channel: one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= `RESP_OKAY;
         case (s_axi_araddr)
            `ADDR_CTRL: rdata_ff <= ctrl_ff;
            `ADDR_STATUS: rdata_ff <= {24'h00_0000, idx_ff, 1'b0,
               end_ff, analog_ff, state_ff == sweep_handler_pkg::S_IDLE};
            `ADDR_RESULT: rdata_ff <= {21'h00_0000, any_fail_ff,
               point_fail_ff};
            `ADDR_IRQ_STAT: rdata_ff <= {29'h0000_0000, irq_stat_ff};
            `ADDR_IRQ_EN: rdata_ff <= {29'h0000_0000, irq_en_ff};
            `ADDR_IRQ_CLR: rdata_ff <= 32'h0000_0000;
            `ADDR_NPOINTS: rdata_ff <= {28'h000_0000, npoints_ff};
            default: begin
               rdata_ff <= 32'h0000_0000;
               rresp_ff <= `RESP_SLVERR;
            end
         endcase
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign s_axi_arready = ~rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // Result pins never change outside the latch cycle.
   results_stable_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !(state_ff == sweep_handler_pkg::S_COMPARE && compare_done_in &&
        last_point) |=> $stable(point_fail))
      else $error("Fail outputs changed outside sweep end.");

   any_fail_or_a: assert property (@(posedge aclk) disable iff (!aresetn)
      any_point_fail == |point_fail)
      else $error("Any-fail does not match point fails.");

   sequence sweep_end_s;
      state_ff == sweep_handler_pkg::S_DONE;
   endsequence

   end_after_sweep_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sweep_end_s |=> measure_complete_strobe)
      else $error("End strobe missing after sweep.");

   strobe_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      start_req |=> !analog_done_strobe && !measure_complete_strobe)
      else $error("Strobes not cleared at start.");

   ext_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (trig_rise && ctrl_ff[`CTRL_EXTERNAL_TRIGGER_EDGE] &&
       state_ff == sweep_handler_pkg::S_IDLE) |=> point_start)
      else $error("Trigger edge did not start a sweep.");

   step_analog_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_ff == sweep_handler_pkg::S_ANALOG && analog_done_in &&
       !ctrl_ff[`CTRL_WHOLE_LIST] && !start_req)
      |=> analog_done_strobe)
      else $error("Step analog strobe missing.");

   list_analog_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_ff == sweep_handler_pkg::S_ANALOG && analog_done_in &&
       ctrl_ff[`CTRL_WHOLE_LIST] && last_point) |=> analog_done_strobe)
      else $error("Whole-list analog strobe missing.");

   step_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_ff == sweep_handler_pkg::S_COMPARE && compare_done_in &&
       !ctrl_ff[`CTRL_WHOLE_LIST]) |-> ##[1:2] measure_complete_strobe)
      else $error("Step end strobe missing.");

   point_fail_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_ff == sweep_handler_pkg::S_COMPARE && compare_done_in &&
       last_point) |=> point_fail == $past(nxt_work))
      else $error("Fail pattern not latched.");
endmodule
`default_nettype wire

/* verif/sweep_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Behavioural measurement engine facing the sweep sequencer.
module sweep_engine_model (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Set-up from the bench.
   input wire logic [3:0] delay,
   input wire logic [9:0] fail_mask,
   // Engine handshake.
   input wire logic point_start,
   input wire logic [3:0] point_index,
   output logic analog_done_in,
   output logic compare_done_in,
   output logic compare_fail_in
);
   logic [3:0] cnt_ff;
   logic phase_ff;

   // Each point takes delay+1 cycles of analog work, then delay+1 of compare.
   // The fail line toggles outside its pulse, so a stale sample shows up.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= 4'h0;
         phase_ff <= 1'b0;
         analog_done_in <= 1'b0;
         compare_done_in <= 1'b0;
         compare_fail_in <= 1'b0;
      end else begin
         analog_done_in <= 1'b0;
         compare_done_in <= 1'b0;
         compare_fail_in <= ~compare_fail_in;
         if (!phase_ff && point_start) begin
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff >= delay) begin
               analog_done_in <= 1'b1;
               cnt_ff <= 4'h0;
               phase_ff <= 1'b1;
            end
         end else if (phase_ff) begin
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff >= delay) begin
               compare_done_in <= 1'b1;
               compare_fail_in <= fail_mask[point_index];
               cnt_ff <= 4'h0;
               phase_ff <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* verif/list_sweep_handler_outputs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sweep_handler_defines.svh"
module list_sweep_handler_outputs_bench;
   logic aclk, aresetn, external_trigger_edge, point_start, irq;
   logic analog_done_in, compare_done_in, compare_fail_in;
   logic [3:0] point_index, delay, s_axi_wstrb;
   logic [9:0] point_fail, fail_mask;
   logic any_point_fail, analog_done_strobe, measure_complete_strobe;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, an_q, end_q;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [31:0] rd;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   int an_rises = 0;
   int end_rises = 0;

   list_sweep_handler_outputs list_sweep_handler_outputs_inst (.aclk,
      .aresetn, .external_trigger_edge, .point_start, .point_index,
      .analog_done_in, .compare_done_in, .compare_fail_in, .point_fail,
      .any_point_fail, .analog_done_strobe, .measure_complete_strobe, .irq,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   sweep_engine_model sweep_engine_model_inst (.aclk, .aresetn, .delay,
      .fail_mask, .point_start, .point_index, .analog_done_in,
      .compare_done_in, .compare_fail_in);

   // Free-running 250 MHz clock.
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   // Strobe rises are counted here; the watchdog cuts a hang short.
   always @(posedge aclk) begin
      an_q <= analog_done_strobe;
      end_q <= measure_complete_strobe;
      if (analog_done_strobe === 1'b1 && an_q === 1'b0) an_rises++;
      if (measure_complete_strobe === 1'b1 && end_q === 1'b0) end_rises++;
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         $display("CHECK FAILED at %0t: watchdog expired", $time);
         wrap_up();
      end
   end

   task automatic wrap_up;
      $display("errors %0d comparisons %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: resp %h want %h", $time, got, exp);
      end
   endtask

   // Address and data are offered together; each drops once taken.
   task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                            input logic [1:0] er);
      logic aw_ok, w_ok, b_ok;
      @(posedge aclk);
      aw_ok = 1'b0;
      w_ok = 1'b0;
      b_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b_ok) begin
         @(posedge aclk);
         if (aw_ok && w_ok && s_axi_bvalid === 1'b1) begin
            b_ok = 1'b1;
            s_axi_bready <= 1'b0;
            check_resp(s_axi_bresp, er);
         end
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
   endtask

   task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      logic a_ok;
      @(posedge aclk);
      a_ok = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!(a_ok && s_axi_rvalid === 1'b1)) begin
         @(posedge aclk);
         if (!a_ok && s_axi_arready === 1'b1) begin
            a_ok = 1'b1;
            s_axi_arvalid <= 1'b0;
         end
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // A clean rising edge, held long enough for the edge detector.
   task automatic pulse_trigger;
      @(posedge aclk);
      external_trigger_edge <= 1'b1;
      repeat (3) @(posedge aclk);
      external_trigger_edge <= 1'b0;
   endtask

   task automatic wait_end(input int n);
      while (end_rises < n) @(posedge aclk);
      @(posedge aclk);
   endtask

   task automatic read_check(input logic [31:0] a, input logic [31:0] exp);
      axi_read(a, rd, rr);
      check_resp(rr, `RESP_OKAY);
      check_word(rd, exp);
   endtask

   // Main sequence: reset state, two whole-list sweeps, a step sweep, irq.
   initial begin
      aresetn = 1'b0;
      external_trigger_edge = 1'b0;
      delay = 4'h5;
      fail_mask = 10'h201;
      s_axi_awaddr = 32'h0000_0000;
      s_axi_wdata = 32'h0000_0000;
      s_axi_araddr = 32'h0000_0000;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      read_check(`ADDR_CTRL, 32'h0000_0001);
      read_check(`ADDR_NPOINTS, 32'h0000_000a);
      read_check(`ADDR_IRQ_EN, 32'h0000_0000);
      read_check(`ADDR_STATUS, 32'h0000_0001);
      axi_read(32'h0000_001c, rd, rr);
      check_resp(rr, `RESP_SLVERR);
      check_word(rd, 32'h0000_0000);
      axi_write(32'h0000_0020, 32'h0000_0001, `RESP_SLVERR);
      axi_write(32'h0000_0002, 32'h0000_0000, `RESP_SLVERR);
      read_check(`ADDR_CTRL, 32'h0000_0001);
      axi_write(`ADDR_CTRL, 32'h0000_0003, `RESP_OKAY);
      pulse_trigger();
      wait_end(1);
      check_word(an_rises, 1);
      check_word(end_rises, 1);
      check_word({21'h0, any_point_fail, point_fail}, 32'h0000_0601);
      read_check(`ADDR_RESULT, 32'h0000_0601);
      fail_mask <= 10'h000;
      pulse_trigger();
      while (point_start !== 1'b1) @(posedge aclk);
      check_word({analog_done_strobe, measure_complete_strobe}, 0);
      while (an_rises < 2) @(posedge aclk);
      // No analog work is pending once the strobe is up, so a part swap
      // here cannot disturb the sweep.
      check_word({31'h0, point_start}, 32'h0000_0000);
      check_word({22'h0, point_fail}, 32'h0000_0201);
      wait_end(2);
      check_word({21'h0, any_point_fail, point_fail}, 32'h0000_0000);
      axi_write(`ADDR_NPOINTS, 32'h0000_0003, `RESP_OKAY);
      // Counts outside one to ten are dropped and the old count stays.
      axi_write(`ADDR_NPOINTS, 32'h0000_000b, `RESP_OKAY);
      read_check(`ADDR_NPOINTS, 32'h0000_0003);
      axi_write(`ADDR_IRQ_EN, 32'h0000_0002, `RESP_OKAY);
      delay <= 4'h2;
      fail_mask <= 10'h3f6;
      axi_write(`ADDR_CTRL, 32'h0000_0004, `RESP_OKAY);
      wait_end(5);
      check_word(an_rises, 5);
      check_word(end_rises, 5);
      check_word({21'h0, any_point_fail, point_fail}, 32'h0000_0406);
      // External trigger is now disabled: an edge must leave the sweep idle
      // with the last index and both strobes still shown.
      pulse_trigger();
      read_check(`ADDR_STATUS, 32'h0000_0027);
      check_word({31'h0, irq}, 32'h0000_0001);
      read_check(`ADDR_IRQ_STAT, 32'h0000_0007);
      axi_write(`ADDR_IRQ_CLR, 32'h0000_0002, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      check_word({31'h0, irq}, 32'h0000_0000);
      read_check(`ADDR_IRQ_STAT, 32'h0000_0005);
      axi_write(`ADDR_IRQ_EN, 32'h0000_0001, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      check_word({31'h0, irq}, 32'h0000_0001);
      axi_write(`ADDR_IRQ_CLR, 32'h0000_0007, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      check_word({31'h0, irq}, 32'h0000_0000);
      read_check(`ADDR_IRQ_STAT, 32'h0000_0000);
      wrap_up();
   end
endmodule
`default_nettype wire
